// [mpbd_pkg.sv]
`default_nettype none
package mpbd_pkg;
  // register byte addresses on the control bus
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_DESC = 8'h04;
  localparam logic [7:0] REG_STAT = 8'h08;
  localparam logic [7:0] REG_ISR  = 8'h0c;
  localparam logic [7:0] REG_IMR  = 8'h10;
  localparam logic [1:0] RESP_OK  = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;
  localparam int         NEV      = 3;
  localparam int         EV_STALL = 2;
  // descriptor entry halfword byte offsets
  localparam logic [31:0] OFF_HDR  = 32'h0000_0000;
  localparam logic [31:0] OFF_ST1  = 32'h0000_0004;
  localparam logic [31:0] OFF_ST2  = 32'h0000_0006;
  localparam logic [31:0] OFF_BA1  = 32'h0000_0008;
  localparam logic [31:0] OFF_BA2  = 32'h0000_000c;
  localparam logic [31:0] OFF_HALF = 32'h0000_0002;
  localparam logic [2:0]  FETCH_N  = 3'h6;
  // header and per-buffer status field positions
  localparam int BIT_CE   = 15;
  localparam int BIT_LE   = 14;
  localparam int BIT_PG   = 13;
  localparam int BIT_RDY  = 15;
  localparam int BIT_DNE  = 14;
  localparam int BIT_ERR  = 13;
  localparam int BIT_PS   = 12;
  localparam int DEPTH_HI = 11;
  localparam logic [11:0] ONE12 = 12'h001;
  localparam logic [2:0]  ONE3  = 3'h1;
  localparam logic        SIZE_BYTE = 1'b0;
  localparam logic        SIZE_HALF = 1'b1;

  typedef enum logic [2:0] {
    ST_IDLE, ST_FETCH, ST_PAUSE, ST_RX, ST_WBYTE, ST_WDONE
  } mpbd_state_t;

  // byte offset of descriptor halfword fetched at step idx
  function automatic logic [31:0] fetch_off(input logic [2:0] idx);
    unique case (idx)
      3'h0: fetch_off = OFF_HDR;
      3'h1: fetch_off = OFF_ST1;
      3'h2: fetch_off = OFF_ST2;
      3'h3: fetch_off = OFF_BA1;
      3'h4: fetch_off = OFF_BA1 + OFF_HALF;
      3'h5: fetch_off = OFF_BA2;
      default: fetch_off = OFF_BA2 + OFF_HALF;
    endcase
  endfunction
endpackage
`default_nettype wire

// [mpbd_regs.sv]
`default_nettype none
module mpbd_regs (
  input  wire logic        i_clk,
  input  wire logic        i_rstn,
  input  wire logic        i_ce,
  input  wire logic [7:0]  i_awaddr,
  input  wire logic        i_awvalid,
  output logic             o_awready,
  input  wire logic [31:0] i_wdata,
  input  wire logic [3:0]  i_wstrb,
  input  wire logic        i_wvalid,
  output logic             o_wready,
  output logic [1:0]       o_bresp,
  output logic             o_bvalid,
  input  wire logic        i_bready,
  input  wire logic [7:0]  i_araddr,
  input  wire logic        i_arvalid,
  output logic             o_arready,
  output logic [31:0]      o_rdata,
  output logic [1:0]       o_rresp,
  output logic             o_rvalid,
  input  wire logic        i_rready,
  input  wire logic [31:0] i_status,
  input  wire logic [2:0]  i_events,
  output logic             o_enable,
  output logic [31:0]      o_desc_base,
  output logic             o_irq
);
  typedef struct packed {
    logic        aw_ok;
    logic [7:0]  awaddr;
    logic        w_ok;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        enable;
    logic [31:0] desc;
    logic [2:0]  isr;
    logic [2:0]  imr;
  } mpbd_regs_t;

  mpbd_regs_t r;
  mpbd_regs_t next_r;

  // merge written bytes over the old value
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  strb);
    merge = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) merge[b*8 +: 8] = nw[b*8 +: 8];
    end
  endfunction

  assign o_awready   = !r.aw_ok && !r.bvalid;
  assign o_wready    = !r.w_ok && !r.bvalid;
  assign o_arready   = !r.rvalid;
  assign o_bvalid    = r.bvalid;
  assign o_bresp     = r.bresp;
  assign o_rvalid    = r.rvalid;
  assign o_rdata     = r.rdata;
  assign o_rresp     = r.rresp;
  assign o_enable    = r.enable;
  assign o_desc_base = r.desc;
  assign o_irq       = |(r.isr & r.imr);

  // address and data are taken in either order, answered once both are in
  always_comb begin
    logic [2:0]  clr;
    logic [31:0] m;
    clr    = '0;
    m      = '0;
    next_r = r;
    if (i_awvalid && o_awready) begin
      next_r.aw_ok  = 1'b1;
      next_r.awaddr = i_awaddr;
    end
    if (i_wvalid && o_wready) begin
      next_r.w_ok  = 1'b1;
      next_r.wdata = i_wdata;
      next_r.wstrb = i_wstrb;
    end
    if (r.aw_ok && r.w_ok) begin
      next_r.aw_ok  = 1'b0;
      next_r.w_ok   = 1'b0;
      next_r.bvalid = 1'b1;
      next_r.bresp  = mpbd_pkg::RESP_OK;
      m = merge('0, r.wdata, r.wstrb);
      unique case (r.awaddr)
        mpbd_pkg::REG_CTRL: next_r.enable = r.wstrb[0] ? m[0] : r.enable;
        mpbd_pkg::REG_DESC: next_r.desc = merge(r.desc, r.wdata, r.wstrb);
        mpbd_pkg::REG_IMR:  next_r.imr = r.wstrb[0] ? m[2:0] : r.imr;
        mpbd_pkg::REG_STAT, mpbd_pkg::REG_ISR: ;
        default: next_r.bresp = mpbd_pkg::RESP_ERR;
      endcase
    end
    if (r.bvalid && i_bready) next_r.bvalid = 1'b0;
    if (r.rvalid && i_rready) next_r.rvalid = 1'b0;
    if (i_arvalid && o_arready) begin
      next_r.rvalid = 1'b1;
      next_r.rresp  = mpbd_pkg::RESP_OK;
      next_r.rdata  = '0;
      unique case (i_araddr)
        mpbd_pkg::REG_CTRL: next_r.rdata[0] = r.enable;
        mpbd_pkg::REG_DESC: next_r.rdata = r.desc;
        mpbd_pkg::REG_STAT: next_r.rdata = i_status;
        mpbd_pkg::REG_ISR: begin
          next_r.rdata[2:0] = r.isr;
          clr = r.isr; // read clears what was shown
        end
        mpbd_pkg::REG_IMR:  next_r.rdata[2:0] = r.imr;
        default: next_r.rresp = mpbd_pkg::RESP_ERR;
      endcase
    end
    // a new event in the clearing cycle survives the clear
    next_r.isr = (r.isr & ~clr) | i_events;
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) r <= '0;
    else if (i_ce) r <= next_r;
  end
endmodule
`default_nettype wire

// [mpbd_top.sv]
`default_nettype none
module mpbd_top (
  input  wire logic        i_clk,
  input  wire logic        i_rstn,
  input  wire logic        i_ce,
  input  wire logic [7:0]  i_awaddr,
  input  wire logic        i_awvalid,
  output logic             o_awready,
  input  wire logic [31:0] i_wdata,
  input  wire logic [3:0]  i_wstrb,
  input  wire logic        i_wvalid,
  output logic             o_wready,
  output logic [1:0]       o_bresp,
  output logic             o_bvalid,
  input  wire logic        i_bready,
  input  wire logic [7:0]  i_araddr,
  input  wire logic        i_arvalid,
  output logic             o_arready,
  output logic [31:0]      o_rdata,
  output logic [1:0]       o_rresp,
  output logic             o_rvalid,
  input  wire logic        i_rready,
  output logic             o_irq,
  input  wire logic [7:0]  i_rx_data,
  input  wire logic        i_rx_last,
  input  wire logic        i_rx_valid,
  output logic             o_rx_ready,
  output logic             o_mem_req,
  output logic             o_mem_we,
  output logic             o_mem_size,
  output logic [31:0]      o_mem_addr,
  output logic [15:0]      o_mem_wdata,
  input  wire logic [15:0] i_mem_rdata,
  input  wire logic        i_mem_ack
);
  typedef struct packed {
    mpbd_pkg::mpbd_state_t st;
    logic [2:0]            fidx;
    logic                  ce_flag;
    logic                  last_entry_flag;
    logic                  page_select_flag;
    logic [1:0][15:0]      bstat;
    logic [1:0][31:0]      bbase;
    logic                  sel;
    logic [11:0]           cnt;
    logic                  pkt_last;
    logic                  req;
    logic                  we;
    logic                  size;
    logic [31:0]           addr;
    logic [15:0]           wdata;
    logic [2:0]            ev;
  } mpbd_core_t;

  mpbd_core_t s;
  mpbd_core_t next_s;
  logic       enable;
  logic [31:0] desc_base;
  logic [31:0] status;

  assign status = {15'h0000, s.st != mpbd_pkg::ST_IDLE, s.page_select_flag,
                   s.last_entry_flag, s.ce_flag, s.sel, s.cnt};

  mpbd_regs u_regs (
    .i_clk       (i_clk),
    .i_rstn      (i_rstn),
    .i_ce        (i_ce),
    .i_awaddr    (i_awaddr),
    .i_awvalid   (i_awvalid),
    .o_awready   (o_awready),
    .i_wdata     (i_wdata),
    .i_wstrb     (i_wstrb),
    .i_wvalid    (i_wvalid),
    .o_wready    (o_wready),
    .o_bresp     (o_bresp),
    .o_bvalid    (o_bvalid),
    .i_bready    (i_bready),
    .i_araddr    (i_araddr),
    .i_arvalid   (i_arvalid),
    .o_arready   (o_arready),
    .o_rdata     (o_rdata),
    .o_rresp     (o_rresp),
    .o_rvalid    (o_rvalid),
    .i_rready    (i_rready),
    .i_status    (status),
    .i_events    (s.ev),
    .o_enable    (enable),
    .o_desc_base (desc_base),
    .o_irq       (o_irq)
  );

  // memory request holds until acknowledged
  assign o_mem_req   = s.req;
  assign o_mem_we    = s.we;
  assign o_mem_size  = s.size;
  assign o_mem_addr  = s.addr;
  assign o_mem_wdata = s.wdata;

  logic [15:0] cur_stat;
  logic [11:0] depth;
  logic [11:0] cnt1;
  logic        buf_usable;
  logic [31:0] st_off;

  assign cur_stat   = s.bstat[s.sel];
  assign depth      = cur_stat[mpbd_pkg::DEPTH_HI:0];
  assign cnt1       = s.cnt + mpbd_pkg::ONE12;
  assign buf_usable = cur_stat[mpbd_pkg::BIT_RDY] &&
                      !cur_stat[mpbd_pkg::BIT_DNE];
  assign st_off     = s.sel ? mpbd_pkg::OFF_ST2 : mpbd_pkg::OFF_ST1;

  // bytes are only taken while a usable buffer still has room
  assign o_rx_ready = (s.st == mpbd_pkg::ST_RX) && enable &&
                      (s.cnt != depth);

  // packet-start flag is never written on receive; software ignores it
  always_comb begin
    next_s    = s;
    next_s.ev = '0;
    unique case (s.st)
      mpbd_pkg::ST_IDLE: begin
        if (enable) begin
          next_s.st   = mpbd_pkg::ST_FETCH;
          next_s.fidx = '0;
          next_s.req  = 1'b1;
          next_s.we   = 1'b0;
          next_s.size = mpbd_pkg::SIZE_HALF;
          next_s.addr = desc_base + mpbd_pkg::fetch_off('0);
        end
      end
      mpbd_pkg::ST_FETCH: begin
        if (i_mem_ack) begin
          // unpack the fixed entry layout halfword by halfword
          unique case (s.fidx)
            3'h0: begin
              next_s.ce_flag          = i_mem_rdata[mpbd_pkg::BIT_CE];
              next_s.last_entry_flag  = i_mem_rdata[mpbd_pkg::BIT_LE];
              next_s.page_select_flag = i_mem_rdata[mpbd_pkg::BIT_PG];
            end
            3'h1: next_s.bstat[0] = i_mem_rdata;
            3'h2: next_s.bstat[1] = i_mem_rdata;
            3'h3: next_s.bbase[0][15:0] = i_mem_rdata;
            3'h4: next_s.bbase[0][31:16] = i_mem_rdata;
            3'h5: next_s.bbase[1][15:0] = i_mem_rdata;
            default: next_s.bbase[1][31:16] = i_mem_rdata;
          endcase
          next_s.fidx = s.fidx + mpbd_pkg::ONE3;
          next_s.addr = desc_base + mpbd_pkg::fetch_off(next_s.fidx);
          if (s.fidx == mpbd_pkg::FETCH_N) begin
            next_s.req = 1'b0;
            next_s.st  = mpbd_pkg::ST_PAUSE;
          end
        end
      end
      mpbd_pkg::ST_PAUSE: begin
        // decide on the freshly fetched entry
        if (!enable || !s.ce_flag) begin
          next_s.st = mpbd_pkg::ST_IDLE;
        end else if (buf_usable) begin
          next_s.st = mpbd_pkg::ST_RX;
        end else begin
          // active buffer not ready: flag it and poll the entry again
          next_s.ev[mpbd_pkg::EV_STALL] = 1'b1;
          next_s.st = mpbd_pkg::ST_IDLE;
        end
      end
      mpbd_pkg::ST_RX: begin
        if (!enable) begin
          next_s.st = mpbd_pkg::ST_IDLE;
        end else if (s.cnt == depth) begin
          // zero-depth buffer counts as already full
          next_s.st    = mpbd_pkg::ST_WDONE;
          next_s.req   = 1'b1;
          next_s.we    = 1'b1;
          next_s.size  = mpbd_pkg::SIZE_HALF;
          next_s.addr  = desc_base + st_off;
          next_s.wdata = cur_stat | (16'h0001 << mpbd_pkg::BIT_DNE);
        end else if (i_rx_valid) begin
          next_s.st       = mpbd_pkg::ST_WBYTE;
          next_s.pkt_last = i_rx_last;
          next_s.req      = 1'b1;
          next_s.we       = 1'b1;
          next_s.size     = mpbd_pkg::SIZE_BYTE;
          next_s.addr     = s.bbase[s.sel] + {20'h00000, s.cnt};
          next_s.wdata    = {8'h00, i_rx_data};
        end
      end
      mpbd_pkg::ST_WBYTE: begin
        if (i_mem_ack) begin
          next_s.req = 1'b0;
          next_s.cnt = cnt1;
          // full, or a packet ending one byte short of the end
          if (cnt1 == depth ||
              (s.pkt_last && cnt1 == depth - mpbd_pkg::ONE12)) begin
            next_s.st    = mpbd_pkg::ST_WDONE;
            next_s.req   = 1'b1;
            next_s.size  = mpbd_pkg::SIZE_HALF;
            next_s.addr  = desc_base + st_off;
            next_s.wdata = cur_stat | (16'h0001 << mpbd_pkg::BIT_DNE);
          end else begin
            next_s.st = mpbd_pkg::ST_RX;
          end
        end
      end
      mpbd_pkg::ST_WDONE: begin
        if (i_mem_ack) begin
          // packet may carry on into the other buffer unchanged
          next_s.req        = 1'b0;
          next_s.we         = 1'b0;
          next_s.ev[s.sel]  = 1'b1;
          next_s.sel        = !s.sel;
          next_s.cnt        = '0;
          next_s.st         = mpbd_pkg::ST_IDLE;
        end
      end
      default: next_s.st = mpbd_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      s    <= '0;
      s.st <= mpbd_pkg::ST_IDLE;
    end else if (i_ce) begin
      s <= next_s;
    end
  end
endmodule
`default_nettype wire

// [mpbd_properties.sv]
`default_nettype none
module mpbd_chk (
  input wire logic        i_clk,
  input wire logic        i_rstn,
  input wire logic        i_arvalid,
  input wire logic        o_arready,
  input wire logic [31:0] o_rdata,
  input wire logic        o_rvalid,
  input wire logic        i_rready,
  input wire logic [1:0]  o_bresp,
  input wire logic        o_bvalid,
  input wire logic        i_bready,
  input wire logic        i_rx_valid,
  input wire logic        o_rx_ready,
  input wire logic        o_mem_req,
  input wire logic        o_mem_we,
  input wire logic        o_mem_size,
  input wire logic [31:0] o_mem_addr,
  input wire logic [15:0] o_mem_wdata,
  input wire logic        i_mem_ack
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  // a byte taken from the stream and the byte store it causes
  sequence s_byte_taken;
    i_rx_valid && o_rx_ready;
  endsequence
  sequence s_byte_store;
    o_mem_req && o_mem_we && !o_mem_size;
  endsequence
  a_rx_store: assert property (s_byte_taken |=> s_byte_store)
    else $error("stream byte not stored");
  a_store_once: assert property (s_byte_store ##0 i_mem_ack |=>
    !(o_mem_req && o_mem_we && !o_mem_size))
    else $error("byte stored twice");
  a_rx_busy: assert property (o_mem_req |-> !o_rx_ready)
    else $error("stream accepted during memory access");
  a_done_word: assert property (o_mem_req && o_mem_we && o_mem_size |->
    o_mem_wdata[15:14] == 2'b11 && !o_mem_addr[0])
    else $error("status writeback lacks ready or done");
  a_fetch_half: assert property (o_mem_req && !o_mem_we |->
    o_mem_size && !o_mem_addr[0])
    else $error("entry fetch not an aligned halfword");
  // requests must not move while the far side is still slow
  a_req_hold: assert property (o_mem_req && !i_mem_ack |=> o_mem_req
    && $stable(o_mem_addr) && $stable(o_mem_wdata) && $stable(o_mem_we))
    else $error("memory request changed before ack");
  a_bresp_hold: assert property (o_bvalid && !i_bready |=>
    o_bvalid && $stable(o_bresp))
    else $error("write answer dropped early");
  a_rdata_hold: assert property (o_rvalid && !i_rready |=>
    o_rvalid && $stable(o_rdata))
    else $error("read answer dropped early");
  a_read_answer: assert property (i_arvalid && o_arready |=> o_rvalid)
    else $error("read answer late");
endmodule
bind mpbd_top mpbd_chk chk_u (.i_clk(i_clk), .i_rstn(i_rstn),
  .i_arvalid(i_arvalid), .o_arready(o_arready), .o_rdata(o_rdata),
  .o_rvalid(o_rvalid), .i_rready(i_rready), .o_bresp(o_bresp),
  .o_bvalid(o_bvalid), .i_bready(i_bready), .i_rx_valid(i_rx_valid),
  .o_rx_ready(o_rx_ready), .o_mem_req(o_mem_req), .o_mem_we(o_mem_we),
  .o_mem_size(o_mem_size), .o_mem_addr(o_mem_addr),
  .o_mem_wdata(o_mem_wdata), .i_mem_ack(i_mem_ack));
`default_nettype wire

// [mpbd_mem_model.sv]
`default_nettype none
module mpbd_mem_model (
  input  wire logic        i_clk,
  input  wire logic        i_req,
  input  wire logic        i_we,
  input  wire logic        i_size,
  input  wire logic [31:0] i_addr,
  input  wire logic [15:0] i_wdata,
  output logic [15:0]      o_rdata,
  output logic             o_ack
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [256];
  logic [7:0] a;
  logic [1:0] dly;
  int         seed;
  // entry at 0 prepared by software, buffers at 0x40 and 0x80
  // receive-only partner: no transmit buffer is ever sized or split
  initial begin
    seed = 32'he0e3;
    dly = 2'h0;
    o_ack = 1'b0;
    o_rdata = 16'h0000;
    foreach (mem[i]) mem[i] = 8'h00;
    {mem[1], mem[0]} = 16'h8000;
    // packet-start bits left clear: software never relies on them here
    {mem[5], mem[4]} = 16'h8004;
    {mem[7], mem[6]} = 16'h8004;
    mem[8] = 8'h40;
    mem[12] = 8'h80;
  end
  assign a = i_addr[7:0];
  // random 0..3 cycle wait; idle read bus toggles so stale data fails
  always @(posedge i_clk) begin
    o_ack <= 1'b0;
    o_rdata <= ~o_rdata;
    if (i_req && !o_ack) begin
      if (dly == 2'h0) begin
        o_ack <= 1'b1;
        o_rdata <= {mem[a + 8'h01], mem[a]};
        if (i_we) mem[a] <= i_wdata[7:0];
        if (i_we && i_size) mem[a + 8'h01] <= i_wdata[15:8];
        dly <= 2'($random(seed));
      end else begin
        dly <= dly - 2'h1;
      end
    end
  end
endmodule
`default_nettype wire

// [testbench.sv]
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin \
  err_count++; $display("wrong value %s exp %h got %h", nm, e, g); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        i_clk, i_rstn, i_awvalid, i_wvalid, i_bready, i_arvalid;
  logic        i_rready, i_rx_last, i_rx_valid, i_mem_ack;
  logic [7:0]  i_awaddr, i_araddr, i_rx_data;
  logic [31:0] i_wdata, o_rdata, o_mem_addr;
  logic [15:0] i_mem_rdata, o_mem_wdata;
  logic        o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_irq;
  logic        o_rx_ready, o_mem_req, o_mem_we, o_mem_size;
  logic [1:0]  o_bresp, o_rresp;
  logic [33:0] q_ax [$];
  logic [48:0] q_mem [$];
  logic [33:0] ex_ax;
  logic [48:0] ex_mem, got_mem;
  logic [7:0]  pkt [7];
  int          err_count, n_checks, seed, k;
  mpbd_top dut_u (.i_clk(i_clk), .i_rstn(i_rstn), .i_ce(1'b1),
    .i_awaddr(i_awaddr), .i_awvalid(i_awvalid), .o_awready(o_awready),
    .i_wdata(i_wdata), .i_wstrb(4'hf), .i_wvalid(i_wvalid),
    .o_wready(o_wready), .o_bresp(o_bresp), .o_bvalid(o_bvalid),
    .i_bready(i_bready), .i_araddr(i_araddr), .i_arvalid(i_arvalid),
    .o_arready(o_arready), .o_rdata(o_rdata), .o_rresp(o_rresp),
    .o_rvalid(o_rvalid), .i_rready(i_rready), .o_irq(o_irq),
    .i_rx_data(i_rx_data), .i_rx_last(i_rx_last), .i_rx_valid(i_rx_valid),
    .o_rx_ready(o_rx_ready), .o_mem_req(o_mem_req), .o_mem_we(o_mem_we),
    .o_mem_size(o_mem_size), .o_mem_addr(o_mem_addr),
    .o_mem_wdata(o_mem_wdata), .i_mem_rdata(i_mem_rdata),
    .i_mem_ack(i_mem_ack));
  mpbd_mem_model mem_u (.i_clk(i_clk), .i_req(o_mem_req),
    .i_we(o_mem_we), .i_size(o_mem_size), .i_addr(o_mem_addr),
    .i_wdata(o_mem_wdata), .o_rdata(i_mem_rdata), .o_ack(i_mem_ack));
  initial begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end
  task automatic stop_test(input logic hang);
    if (hang) err_count++;
    if (err_count == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // one register access; each channel released at the edge it is taken
  task automatic axi(input logic rd, input logic [7:0] a,
                     input logic [31:0] d, input logic [1:0] r);
    logic aw_t, w_t, ar_t, b_t;
    int   lag;
    @(posedge i_clk);
    // answer ready comes 0..3 edges late so the answer must wait
    lag = $random(seed) & 3;
    q_ax.push_back({r, rd ? d : 32'h0000_0000});
    i_awaddr <= a;
    i_araddr <= a;
    i_wdata <= d;
    {i_awvalid, i_wvalid} <= {2{!rd}};
    i_arvalid <= rd;
    for (k = 0; k < 200; k++) begin
      @(negedge i_clk);
      aw_t = o_awready;
      w_t = o_wready;
      ar_t = o_arready;
      b_t = rd ? (o_rvalid && i_rready) : (o_bvalid && i_bready);
      @(posedge i_clk);
      if (aw_t) i_awvalid <= 1'b0;
      if (w_t) i_wvalid <= 1'b0;
      if (ar_t) i_arvalid <= 1'b0;
      if (b_t) break;
      if (k >= lag) {i_bready, i_rready} <= {!rd, rd};
    end
    {i_bready, i_rready} <= 2'b00;
    if (k == 200) stop_test(1'b1);
  endtask
  // one stream byte, held until the block takes it
  task automatic rx_byte(input logic [7:0] d, input logic last);
    logic hs;
    @(posedge i_clk);
    i_rx_data <= d;
    i_rx_last <= last;
    i_rx_valid <= 1'b1;
    for (k = 0; k < 200; k++) begin
      @(negedge i_clk);
      hs = o_rx_ready;
      @(posedge i_clk);
      if (hs) break;
    end
    i_rx_valid <= 1'b0;
    i_rx_data <= ~d;
    if (k == 200) stop_test(1'b1);
  endtask
  // answers and memory writes are compared with the oldest note
  always @(posedge i_clk) begin
    if ((o_bvalid && i_bready) || (o_rvalid && i_rready)) begin
      ex_ax = q_ax.pop_front();
      if (o_bvalid) `CHK("write answer", ex_ax, {o_bresp, 32'h0000_0000})
      else `CHK("read answer", ex_ax, {o_rresp, o_rdata})
    end
    if (o_mem_req && o_mem_we && i_mem_ack) begin
      ex_mem = q_mem.pop_front();
      got_mem = {o_mem_size, o_mem_addr,
                 o_mem_size ? o_mem_wdata : {8'h00, o_mem_wdata[7:0]}};
      `CHK("memory write", ex_mem, got_mem)
    end
  end
  initial begin
    {err_count, n_checks} = '0;
    seed = 32'he0e3;
    {i_rstn, i_awvalid, i_wvalid, i_bready, i_arvalid} = '0;
    {i_rready, i_rx_valid, i_rx_last} = '0;
    {i_awaddr, i_araddr, i_rx_data, i_wdata} = '0;
    repeat (10) @(posedge i_clk);
    i_rstn <= 1'b1;
    axi(1'b1, mpbd_pkg::REG_ISR, 32'h0, mpbd_pkg::RESP_OK);
    axi(1'b0, 8'h14, 32'h1, mpbd_pkg::RESP_ERR);
    axi(1'b1, 8'h14, 32'h0, mpbd_pkg::RESP_ERR);
    axi(1'b0, mpbd_pkg::REG_DESC, 32'h0, mpbd_pkg::RESP_OK);
    axi(1'b0, mpbd_pkg::REG_IMR, 32'h4, mpbd_pkg::RESP_OK);
    // packet of 7 fills buffer one and ends one short in buffer two
    for (int i = 0; i < 7; i++) begin
      // leading byte is the length header software finds the end by
      pkt[i] = (i == 0) ? 8'h07 : 8'($random(seed));
      q_mem.push_back({1'b0, (i < 4 ? 32'h40 : 32'h7c) + 32'(i),
                       8'h00, pkt[i]});
      if (i == 3) q_mem.push_back({1'b1, 32'h4, 16'hc004});
      if (i == 6) q_mem.push_back({1'b1, 32'h6, 16'hc004});
    end
    axi(1'b0, mpbd_pkg::REG_CTRL, 32'h1, mpbd_pkg::RESP_OK);
    for (int i = 0; i < 7; i++) rx_byte(pkt[i], i == 6);
    // only the masked-in stall event may raise the line
    for (k = 0; k < 400 && o_irq !== 1'b1; k++) @(negedge i_clk);
    if (k == 400) stop_test(1'b1);
    axi(1'b0, mpbd_pkg::REG_CTRL, 32'h0, mpbd_pkg::RESP_OK);
    repeat (40) @(posedge i_clk);
    axi(1'b1, mpbd_pkg::REG_ISR, 32'h7, mpbd_pkg::RESP_OK);
    @(negedge i_clk);
    `CHK("irq after clear", 1'b0, o_irq)
    axi(1'b1, mpbd_pkg::REG_ISR, 32'h0, mpbd_pkg::RESP_OK);
    repeat (2) @(posedge i_clk);
    `CHK("notes left", 0, q_mem.size() + q_ax.size())
    stop_test(1'b0);
  end
endmodule
`default_nettype wire
